/* acbi_top.sv */
// acbi_top: conversion control, busy flag and tri-state result port
// assumes control pins synchronous to clk; testbench resolves the result wires
`timescale 1ns/10ps

// Operation
// - stand-alone: a falling read/convert edge starts a conversion
// - stand-alone: drivers on only with read/convert high and busy low
// - outputs float from start edge until done and enabled again
// - enabled data stays valid 25 ns after read/convert falls
// - result valid before busy falls, with a lead of at least 300 ns
// - half-word pick latched at start; high means 8-bit conversion
// - after 8-bit conversion low three bits zero, fourth bit one
// - start when the last of the three controls reaches its state
// - start delay equal whichever control completes the condition
// - busy high only during conversion; drivers floating then
// - start transitions during conversion do not restart it
// - a start during conversion re-latches the pick, changing length
// - drive only with read/convert high, busy low, activate high, select low
// - word width high drives all twelve bits, pick ignored
// - width low, pick low: eight most significant bits on byte lanes
// - width low, pick high: four low bits then four zeros
// - pick may toggle any time without fault on the drivers
module acbi_top #(
  parameter int unsigned bit_cyc = acbi_pkg::bit_cyc_default
) (
  input wire logic clk,
  input wire logic resetn,
  input wire acbi_pkg::acbi_ctrl_type ctrl,
  input wire logic comp_high,
  output logic busy_flag_out,
  output logic [11:0] result_bits_out,
  output logic [11:0] result_bits_oe
);
  acbi_pkg::acbi_state_type state_q;
  acbi_pkg::acbi_state_type state_d;
  logic start_cond;
  logic start_cond_q;
  logic start_edge;
  logic short_q;
  logic short_d;
  logic [7:0] tick_q;
  logic [7:0] tick_d;
  logic [3:0] bits_q;
  logic [3:0] bits_d;
  logic [8:0] lead_q;
  logic [8:0] lead_d;
  logic [11:0] res_q;
  logic [11:0] res_d;
  logic [11:0] sar_value;
  logic [11:0] sar_trial;
  logic step;
  logic sar_start;
  logic en_now;
  logic [1:0] hold_q;
  logic [1:0] hold_d;
  acbi_pkg::acbi_bus_type bus_d;
  acbi_pkg::acbi_bus_type bus_q;

  function automatic logic [11:0] fmt(input logic [11:0] r, input logic width,
                                     input logic pick);
    if (width) begin
      fmt = r;
    end else if (!pick) begin
      fmt = {4'h0, r[11:4]};
    end else begin
      fmt = {4'h0, r[3:0], 4'h0};
    end
  endfunction : fmt

  // one combined condition: no input is favoured, so delay is uniform
  assign start_cond = ctrl.activate & ~ctrl.unit_select_n & ~ctrl.read_convert;
  assign start_edge = start_cond & ~start_cond_q;
  assign step = (state_q == acbi_pkg::acbi_conv) && (tick_q == 8'(bit_cyc - 1));
  assign sar_start = start_edge && (state_q == acbi_pkg::acbi_idle);

  acbi_sar #(
    .width(acbi_pkg::res_w)
  ) u_sar (
    .clk(clk),
    .resetn(resetn),
    .start(sar_start),
    .step(step),
    .comp_high(comp_high),
    .value_q(sar_value),
    .trial_q(sar_trial)
  );

  always_comb begin
    state_d = state_q;
    short_d = short_q;
    tick_d = tick_q;
    bits_d = bits_q;
    lead_d = lead_q;
    res_d = res_q;
    if (start_edge) begin
      short_d = ctrl.half_word_pick;
    end
    unique case (state_q)
      acbi_pkg::acbi_idle: begin
        if (start_edge) begin
          state_d = acbi_pkg::acbi_conv;
          tick_d = '0;
          bits_d = '0;
        end
      end
      acbi_pkg::acbi_conv: begin
        // restart attempts here only touch the pick latch
        tick_d = step ? 8'h00 : tick_q + 8'h01;
        if (step) begin
          bits_d = bits_q + 4'h1;
          if ((bits_q + 4'h1) >= (short_d ? 4'(acbi_pkg::short_bits)
                                          : 4'(acbi_pkg::full_bits))) begin
            state_d = acbi_pkg::acbi_lead;
            lead_d = '0;
          end
        end
      end
      acbi_pkg::acbi_lead: begin
        if (lead_q == 9'h000) begin
          // short result: remaining bits forced to 1000
          res_d = short_q ? {sar_value[11:4], acbi_pkg::short_tail} : sar_value;
        end
        lead_d = lead_q + 9'h001;
        if (lead_q == 9'(acbi_pkg::lead_cyc)) begin
          state_d = acbi_pkg::acbi_idle;
        end
      end
    endcase
  end

  assign busy_flag_out = (state_q != acbi_pkg::acbi_idle);
  assign en_now = ctrl.read_convert & ~busy_flag_out & ctrl.activate
                  & ~ctrl.unit_select_n;

  always_comb begin
    hold_d = hold_q;
    bus_d = bus_q;
    if (en_now) begin
      hold_d = 2'(acbi_pkg::hold_valid_cyc);
      bus_d.data = fmt(res_q, ctrl.word_width, ctrl.half_word_pick);
      bus_d.oe = ctrl.word_width ? 12'hfff : 12'h0ff;
    end else if (hold_q != 2'h0) begin
      hold_d = hold_q - 2'h1;
    end else begin
      bus_d.oe = 12'h000;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= acbi_pkg::acbi_idle;
      start_cond_q <= 1'b0;
      short_q <= 1'b0;
      tick_q <= '0;
      bits_q <= '0;
      lead_q <= '0;
      res_q <= '0;
      hold_q <= '0;
      bus_q <= '0;
    end else begin
      state_q <= state_d;
      start_cond_q <= start_cond;
      short_q <= short_d;
      tick_q <= tick_d;
      bits_q <= bits_d;
      lead_q <= lead_d;
      res_q <= res_d;
      hold_q <= hold_d;
      bus_q <= bus_d;
    end
  end

  assign result_bits_out = bus_q.data;
  assign result_bits_oe = bus_q.oe;
endmodule : acbi_top

/* acbi_pkg.sv */
// acbi_pkg: constants and carrier types for the converter bus interface
// assumes a single 40 MHz clock domain, no software registers
package acbi_pkg;
  localparam int unsigned clk_period_ns = 25;
  localparam int unsigned hold_valid_ns = 25;
  localparam int unsigned hold_valid_cyc =
    (hold_valid_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned lead_min_ns = 300;
  localparam int unsigned lead_cyc = (lead_min_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned bit_cyc_default = 16;
  localparam int unsigned res_w = 12;
  localparam int unsigned short_bits = 8;
  localparam int unsigned full_bits = 12;
  localparam logic [3:0] short_tail = 4'h8;

  typedef struct packed {
    logic activate;
    logic unit_select_n;
    logic read_convert;
    logic half_word_pick;
    logic word_width;
  } acbi_ctrl_type;

  typedef struct packed {
    logic [11:0] data;
    logic [11:0] oe;
  } acbi_bus_type;

  typedef enum logic [1:0] {
    acbi_idle = 2'b00,
    acbi_conv = 2'b01,
    acbi_lead = 2'b11
  } acbi_state_type;
endpackage : acbi_pkg

/* acbi_sar.sv */
// acbi_sar: successive approximation register stepping one bit per step pulse, which comes every bit_cyc ticks
// assumes comparator input is synchronous and settled each step
`timescale 1ns/10ps
module acbi_sar #(
  parameter int unsigned width = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic step,
  input wire logic comp_high,
  output logic [width-1:0] value_q,
  output logic [width-1:0] trial_q
);
  logic [width-1:0] value_d;
  logic [width-1:0] trial_d;

  always_comb begin
    value_d = value_q;
    trial_d = trial_q;
    if (start) begin
      value_d = {1'b1, {(width-1){1'b0}}};
      trial_d = {1'b1, {(width-1){1'b0}}};
    end else if (step && (trial_q != '0)) begin
      // keep trial bit if the comparator says input is above
      value_d = (comp_high ? value_q : (value_q & ~trial_q)) | (trial_q >> 1);
      trial_d = trial_q >> 1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value_q <= '0;
      trial_q <= '0;
    end else begin
      value_q <= value_d;
      trial_q <= trial_d;
    end
  end
endmodule : acbi_sar

/* acbi_bus_model.sv */
// acbi_bus_model: host side view of the tri-state result lines
// assumes drive and enable come straight from acbi_top
`timescale 1ns/10ps
module acbi_bus_model (
  input wire logic clk,
  input wire logic [11:0] drv,
  input wire logic [11:0] en,
  output logic [11:0] lines
);
  logic [11:0] last_q;
  always_ff @(posedge clk) last_q <= lines;
  // floating lines show the inverse of the last level, never a lucky match
  assign lines = (drv & en) | (~last_q & ~en);
endmodule : acbi_bus_model

/* acbi_chk.sv */
// acbi_chk: port checker for acbi_top
// assumes one clock and the bind at the foot of this file
`timescale 1ns/10ps
module acbi_chk #(
  parameter int unsigned bit_cyc = acbi_pkg::bit_cyc_default
) (
  input wire logic clk,
  input wire logic resetn,
  input wire acbi_pkg::acbi_ctrl_type ctrl,
  input wire logic comp_high,
  input wire logic busy_flag_out,
  input wire logic [11:0] result_bits_out,
  input wire logic [11:0] result_bits_oe
);
  localparam int busy_max = 12 * bit_cyc + 20;
  logic st;
  logic en;
  logic [11:0] oe;
  assign oe = result_bits_oe;
  assign st = ctrl.activate & ~ctrl.unit_select_n & ~ctrl.read_convert;
  assign en = ctrl.read_convert & ~busy_flag_out & ctrl.activate & ~ctrl.unit_select_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_go;
    $rose(st) && !busy_flag_out;
  endsequence
  sequence s_drop;
    en ##1 !en;
  endsequence
  sequence s_rd;
    $past(resetn) && $past(en);
  endsequence
  AST_START: assert property (s_go |=> busy_flag_out)
    else $error("busy did not rise after start");
  AST_FLOAT: assert property (busy_flag_out && $past(busy_flag_out) |-> oe == 12'h000)
    else $error("drivers on during conversion");
  AST_EN: assert property (oe != 12'h000 |-> $past(en) || $past(en, 2))
    else $error("drivers on without enable");
  AST_WORD: assert property (s_rd and $past(ctrl.word_width) |-> oe == 12'hfff)
    else $error("word read not full width");
  AST_BYTE: assert property (s_rd and !$past(ctrl.word_width) |->
    oe == 12'h0ff && result_bits_out[11:8] == 4'h0)
    else $error("byte read lanes wrong");
  AST_NIB: assert property (s_rd and !$past(ctrl.word_width) and $past(ctrl.half_word_pick)
    |-> result_bits_out[3:0] == 4'h0)
    else $error("low byte tail not zero");
  AST_HOLD: assert property (s_drop |=> oe != 12'h000)
    else $error("data not held after read end");
  AST_LEN: assert property ($rose(busy_flag_out) |->
    busy_flag_out [*8] ##[1:busy_max] !busy_flag_out)
    else $error("busy length out of range");
endmodule : acbi_chk
bind acbi_top acbi_chk #(.bit_cyc(bit_cyc)) i_chk (.clk(clk), .resetn(resetn), .ctrl(ctrl),
  .comp_high(comp_high), .busy_flag_out(busy_flag_out), .result_bits_out(result_bits_out),
  .result_bits_oe(result_bits_oe));

/* adc_conversion_bus_interface_tb.sv */
// adc_conversion_bus_interface_tb: directed tests of acbi_top
// assumes short bit time parameter and the host line model
`timescale 1ns/10ps
module adc_conversion_bus_interface_tb;
  localparam int unsigned bc = 2;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  acbi_pkg::acbi_ctrl_type ctrl = 5'b10101;
  logic comp = 1'b1;
  logic busy;
  logic [11:0] dout;
  logic [11:0] oe;
  logic [11:0] lines;
  int n_fail = 0;
  int checked = 0;
  int len12;
  int len8;
  int len;
  always #12.5 clk = ~clk;
  acbi_top #(.bit_cyc(bc)) i_dut (.clk(clk), .resetn(resetn), .ctrl(ctrl), .comp_high(comp),
    .busy_flag_out(busy), .result_bits_out(dout), .result_bits_oe(oe));
  acbi_bus_model i_host (.clk(clk), .drv(dout), .en(oe), .lines(lines));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input logic re, output int n);
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      ctrl.read_convert = !(re && n inside {8, 9});
      cyc(1);
      n++;
    end
    ctrl.read_convert = 1'b1;
    if (n >= 300) n_fail++;
  endtask : wt
  task automatic conv(input logic pick, input logic re, output int n);
    ctrl.half_word_pick = pick;
    ctrl.read_convert = 1'b0;
    cyc(3);
    chk({11'h0, busy}, 12'h001);
    chk(oe, 12'h000);
    wt(re, n);
  endtask : conv
  task automatic rd(input logic ww, input logic pk, input logic [11:0] eo, input logic [11:0] ed);
    ctrl.word_width = ww;
    ctrl.half_word_pick = pk;
    cyc(2);
    chk(oe, eo);
    chk(lines & oe, ed);
  endtask : rd
  task automatic t_gate();
    ctrl.activate = 1'b0;
    cyc(3);
    chk(oe, 12'h000);
    ctrl.read_convert = 1'b0;
    cyc(2);
    chk({11'h0, busy}, 12'h000);
    ctrl.activate = 1'b1;
    cyc(2);
    chk({11'h0, busy}, 12'h001);
    wt(1'b0, len);
  endtask : t_gate
  task automatic wrap_up();
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial begin
    cyc(8);
    resetn = 1'b1;
    cyc(2);
    conv(1'b0, 1'b0, len12);
    rd(1'b1, 1'b1, 12'hfff, 12'hfff);
    rd(1'b0, 1'b0, 12'h0ff, 12'h0ff);
    rd(1'b0, 1'b1, 12'h0ff, 12'h0f0);
    conv(1'b0, 1'b1, len);
    chk(len[11:0], len12[11:0]);
    comp = 1'b0;
    conv(1'b1, 1'b0, len8);
    chk(len12[11:0] - len8[11:0], 12'(4 * bc));
    rd(1'b1, 1'b0, 12'hfff, 12'h008);
    t_gate();
    wrap_up();
  end
endmodule : adc_conversion_bus_interface_tb
